// ### sarrc_top.sv
// Decided for this implementation: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "sarrc_regs.svh"

module sarrc_top
(
    // APB clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // APB slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Analog multiplexer, gain stage and converter core
    input  wire logic                  comp_in,
    output sarrc_pkg::sarrc_analog_t   analog_out,
    // Conversion-complete event level
    output logic                       convert_done
);

    sarrc_pkg::sarrc_apb_req_t req;
    logic [11:0] addr_w;
    logic        setup;
    logic        wr_en;
    logic        rd_low;
    logic        rd_high;
    logic        hit;
    logic [7:0]  rd_byte;

    logic [1:0]  ref_select_r;
    logic        left_justify_r;
    logic [3:0]  channel_select_r;
    logic [3:0]  channel_live_r;
    logic [1:0]  gain_select_r;
    logic        converter_on_r;
    logic        convert_go_r;
    logic [2:0]  prescale_r;
    logic        convert_done_flag_r;
    logic        lock_r;
    logic [9:0]  result_r;
    logic        start_p;

    logic        sar_busy;
    logic        sar_done;
    logic [9:0]  sar_result;
    logic        sar_sample;
    logic [9:0]  sar_trial;

    // Places the code in the high or low byte for either justification
    function automatic logic [7:0] sarrc_fmt(input logic [9:0] code,
                                             input logic       left,
                                             input logic       high);
        logic [15:0] word;
        word = left ? {code, 6'h00} : {6'h00, code};
        return high ? word[15:8] : word[7:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // APB decode; side effects of reads act in the setup cycle
    assign req     = '{psel: psel, penable: penable, pwrite: pwrite,
                       paddr: paddr, pwdata: pwdata};
    assign addr_w  = {req.paddr[11:2], 2'b00};
    assign setup   = req.psel && !req.penable;
    assign wr_en   = req.psel && req.penable && pready && req.pwrite;
    assign rd_low  = setup && !req.pwrite && (addr_w == `SARRC_OFF_RES_LOW);
    assign rd_high = setup && !req.pwrite && (addr_w == `SARRC_OFF_RES_HIGH);

    always_comb
    begin
        hit     = 1'b1;
        rd_byte = `SARRC_ZERO_BYTE;
        if (addr_w == `SARRC_OFF_SETUP)
            rd_byte = {ref_select_r, left_justify_r, 1'b0, channel_select_r};
        else if (addr_w == `SARRC_OFF_CTRL)
            rd_byte = {converter_on_r, convert_go_r, 1'b0, convert_done_flag_r,
                       1'b0, prescale_r};
        else if (addr_w == `SARRC_OFF_RES_LOW)
            rd_byte = sarrc_fmt(result_r, left_justify_r, 1'b0);
        else if (addr_w == `SARRC_OFF_RES_HIGH)
            rd_byte = sarrc_fmt(result_r, left_justify_r, 1'b1);
        else if (addr_w == `SARRC_OFF_GAIN)
            rd_byte = {6'h00, gain_select_r};
        else
            hit = 1'b0;
    end

    // Zero-wait slave: ready is registered, so every access phase lasts one cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= `SARRC_ZERO_WORD;
        end
        else
        begin
            pready  <= setup;
            pslverr <= setup && !hit;
            if (setup && !req.pwrite && hit)
                prdata <= {24'h00_0000, rd_byte};
            else
                prdata <= `SARRC_ZERO_WORD;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Input setup and gain registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ref_select_r     <= 2'h0;
            left_justify_r   <= 1'b0;
            channel_select_r <= 4'h0;
        end
        else if (wr_en && addr_w == `SARRC_OFF_SETUP)
        begin
            ref_select_r     <= {req.pwdata[`SARRC_SETUP_REF_HI],
                                 req.pwdata[`SARRC_SETUP_REF_LO]};
            left_justify_r   <= req.pwdata[`SARRC_SETUP_LEFT];
            channel_select_r <= req.pwdata[`SARRC_SETUP_CH_MSB:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            gain_select_r <= `SARRC_GAIN_RST;
        else if (wr_en && addr_w == `SARRC_OFF_GAIN)
            gain_select_r <= req.pwdata[`SARRC_GAIN_MSB:0];
    end

    // Channel is frozen while converting so the sample stays on one input
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            channel_live_r <= 4'h0;
        else if (!sar_busy)
            channel_live_r <= channel_select_r;
    end

    ////////////////////////////////////////////////////////////////////////
    // Control register A
    assign start_p = wr_en && addr_w == `SARRC_OFF_CTRL
                     && req.pwdata[`SARRC_CTRL_ON] && req.pwdata[`SARRC_CTRL_GO]
                     && !convert_go_r;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            converter_on_r <= 1'b0;
            prescale_r     <= 3'h0;
        end
        else if (wr_en && addr_w == `SARRC_OFF_CTRL)
        begin
            converter_on_r <= req.pwdata[`SARRC_CTRL_ON];
            prescale_r     <= req.pwdata[`SARRC_CTRL_PS_MSB:0];
        end
    end

    // A new start beats the clear from the previous completion
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            convert_go_r <= 1'b0;
        else if (start_p)
            convert_go_r <= 1'b1;
        else if (sar_done || !converter_on_r)
            convert_go_r <= 1'b0;
    end

    // Set wins over a write-one-to-clear in the same cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            convert_done_flag_r <= 1'b0;
        else if (sar_done)
            convert_done_flag_r <= 1'b1;
        else if (wr_en && addr_w == `SARRC_OFF_CTRL && req.pwdata[`SARRC_CTRL_DONE])
            convert_done_flag_r <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Result lock and result register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            lock_r <= 1'b0;
        else if (rd_low)
            lock_r <= 1'b1;
        else if (rd_high)
            lock_r <= 1'b0;
    end

    // A low read in this cycle already counts as locked, keeping the pair coherent
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            result_r <= `SARRC_RES_RST;
        else if (sar_done && !lock_r && !rd_low)
            result_r <= sar_result;
    end

    ////////////////////////////////////////////////////////////////////////
    // Converter core sequencer
    sarrc_sar u_sar
    (
        .pclk        (pclk),
        .presetn     (presetn),
        .enable      (converter_on_r),
        .start       (start_p),
        .div_sel     (prescale_r),
        .comp_in     (comp_in),
        .busy        (sar_busy),
        .done        (sar_done),
        .result      (sar_result),
        .sample_hold (sar_sample),
        .trial       (sar_trial)
    );

    assign analog_out = '{converter_on:   converter_on_r,
                          ref_select:     ref_select_r,
                          channel_select: channel_live_r,
                          gain_select:    gain_select_r,
                          sample_hold:    sar_sample,
                          trial_code:     sar_trial};
    assign convert_done = convert_done_flag_r;

endmodule

// ### sarrc_regs.svh
`ifndef SARRC_REGS_SVH
`define SARRC_REGS_SVH

// Register byte offsets on the APB
`define SARRC_OFF_SETUP     12'h000
`define SARRC_OFF_CTRL      12'h004
`define SARRC_OFF_RES_LOW   12'h008
`define SARRC_OFF_RES_HIGH  12'h00C
`define SARRC_OFF_GAIN      12'h010

// Input setup register fields
`define SARRC_SETUP_REF_HI  7
`define SARRC_SETUP_REF_LO  6
`define SARRC_SETUP_LEFT    5
`define SARRC_SETUP_CH_MSB  3
`define SARRC_SETUP_RST     8'h00

// Control register A fields
`define SARRC_CTRL_ON       7
`define SARRC_CTRL_GO       6
`define SARRC_CTRL_DONE     4
`define SARRC_CTRL_PS_MSB   2
`define SARRC_CTRL_RST      8'h00

// Gain register field
`define SARRC_GAIN_MSB      1
`define SARRC_GAIN_RST      2'h0

// Result and conversion timing
`define SARRC_RES_RST       10'h000
`define SARRC_RES_MSB_MASK  10'h200
`define SARRC_CONV_NORMAL   13
`define SARRC_CONV_FIRST    25
`define SARRC_BIT_TICKS     10
`define SARRC_PRESC_BASE    10'h004
`define SARRC_ZERO_BYTE     8'h00
`define SARRC_ZERO_WORD     32'h0000_0000

`endif

// ### sarrc_pkg.sv
package sarrc_pkg;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SAMPLE,
        ST_BITS,
        ST_FINISH
    } sarrc_state_t;

    typedef struct packed {
        logic       converter_on;
        logic [1:0] ref_select;
        logic [3:0] channel_select;
        logic [1:0] gain_select;
        logic       sample_hold;
        logic [9:0] trial_code;
    } sarrc_analog_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } sarrc_apb_req_t;

endpackage

// ### sarrc_sar.sv
`timescale 1ns/1ps
`include "sarrc_regs.svh"

module sarrc_sar
(
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Control
    input  wire logic       enable,
    input  wire logic       start,
    input  wire logic [2:0] div_sel,
    // Comparator from the analog core
    input  wire logic       comp_in,
    // Status and result
    output logic            busy,
    output logic            done,
    output logic [9:0]      result,
    output logic            sample_hold,
    output logic [9:0]      trial
);

    logic                  comp_meta_r;
    logic                  comp_sync_r;
    logic [9:0]            pre_cnt_r;
    logic [9:0]            div;
    logic                  tick;
    logic                  req_r;
    logic                  first_r;
    sarrc_pkg::sarrc_state_t state_r;
    logic [4:0]            cnt_r;
    logic [4:0]            samp_last_r;
    logic [9:0]            mask_r;
    logic [9:0]            kept;

    ////////////////////////////////////////////////////////////////////////
    // Comparator crossing from the analog side
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            comp_meta_r <= 1'b0;
            comp_sync_r <= 1'b0;
        end
        else
        begin
            comp_meta_r <= comp_in;
            comp_sync_r <= comp_meta_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Prescaler: reset for as long as the converter is off
    assign div  = 10'(`SARRC_PRESC_BASE << div_sel);
    assign tick = enable && (pre_cnt_r == 10'(div - 10'h001));

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pre_cnt_r <= 10'h000;
        else if (!enable || tick)
            pre_cnt_r <= 10'h000;
        else
            pre_cnt_r <= 10'(pre_cnt_r + 10'h001);
    end

    ////////////////////////////////////////////////////////////////////////
    // Pending start, and the longer first conversion after power-up
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            req_r <= 1'b0;
        // Start comes with the write that powers up, so it must beat the off clear
        else if (start)
            req_r <= 1'b1;
        else if (!enable)
            req_r <= 1'b0;
        else if (tick && state_r == sarrc_pkg::ST_IDLE)
            req_r <= 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            first_r <= 1'b1;
        else if (!enable)
            first_r <= 1'b1;
        else if (tick && state_r == sarrc_pkg::ST_IDLE && req_r)
            first_r <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Successive approximation sequencer, one step per converter clock
    assign kept = comp_sync_r ? trial : (trial & ~mask_r);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_r     <= sarrc_pkg::ST_IDLE;
            cnt_r       <= 5'h00;
            samp_last_r <= 5'h00;
            mask_r      <= `SARRC_RES_RST;
            trial       <= `SARRC_RES_RST;
            result      <= `SARRC_RES_RST;
            busy        <= 1'b0;
            done        <= 1'b0;
            sample_hold <= 1'b0;
        end
        else if (!enable)
        begin
            state_r     <= sarrc_pkg::ST_IDLE;
            cnt_r       <= 5'h00;
            busy        <= 1'b0;
            done        <= 1'b0;
            sample_hold <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            if (tick)
            begin
                case (state_r)
                    sarrc_pkg::ST_IDLE:
                        if (req_r)
                        begin
                            state_r     <= sarrc_pkg::ST_SAMPLE;
                            cnt_r       <= 5'h00;
                            busy        <= 1'b1;
                            sample_hold <= 1'b1;
                            // Sample length leaves the start step, ten bit steps and one finish step
                            samp_last_r <= first_r ?
                                5'(`SARRC_CONV_FIRST - `SARRC_BIT_TICKS - 3) :
                                5'(`SARRC_CONV_NORMAL - `SARRC_BIT_TICKS - 3);
                        end
                    sarrc_pkg::ST_SAMPLE:
                        if (cnt_r == samp_last_r)
                        begin
                            state_r     <= sarrc_pkg::ST_BITS;
                            sample_hold <= 1'b0;
                            trial       <= `SARRC_RES_MSB_MASK;
                            mask_r      <= `SARRC_RES_MSB_MASK;
                        end
                        else
                            cnt_r <= 5'(cnt_r + 5'h01);
                    sarrc_pkg::ST_BITS:
                    begin
                        // Keep the trial bit while the input is above the trial level
                        trial  <= kept | (mask_r >> 1);
                        mask_r <= mask_r >> 1;
                        if (mask_r == 10'h001)
                            state_r <= sarrc_pkg::ST_FINISH;
                    end
                    sarrc_pkg::ST_FINISH:
                    begin
                        result  <= trial;
                        done    <= 1'b1;
                        busy    <= 1'b0;
                        state_r <= sarrc_pkg::ST_IDLE;
                    end
                    default:
                        state_r <= sarrc_pkg::ST_IDLE;
                endcase
            end
        end
    end

endmodule

// ### sarrc_top_chk.sv
`timescale 1ns/1ps
`include "sarrc_regs.svh"

module sarrc_top_chk
(
    // Clock and reset
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    // APB slave
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [11:0]              paddr,
    input  wire logic [31:0]              pwdata,
    input  wire logic [31:0]              prdata,
    input  wire logic                     pready,
    input  wire logic                     pslverr,
    // Analog side
    input  wire logic                     comp_in,
    input  wire sarrc_pkg::sarrc_analog_t analog_out,
    input  wire logic                     convert_done
);
default clocking cb @(posedge pclk); endclocking
default disable iff (!presetn);
////////////////////////////////////////////////////////////////////////////////
logic [2:0]  ps_r;
logic        lj_r;
logic [12:0] sh_cnt_r;
wire         wacc_w = psel && penable && pready && pwrite;
wire         clr_w  = wacc_w && paddr[11:2] == 10'h001 && pwdata[4];
// Track prescale and justify so timing and layout can be judged
always_ff @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        ps_r <= 3'h0;
        lj_r <= 1'b0;
    end
    else if (wacc_w && paddr[11:2] == 10'h001)
        ps_r <= pwdata[2:0];
    else if (wacc_w && paddr[11:2] == 10'h000)
        lj_r <= pwdata[5];
end
always_ff @(posedge pclk or negedge presetn)
begin
    if (!presetn)
        sh_cnt_r <= 13'h0000;
    else
        sh_cnt_r <= analog_out.sample_hold ? sh_cnt_r + 13'h0001 : 13'h0000;
end
////////////////////////////////////////////////////////////////////////////////
sequence s_acc(logic [11:0] a);
    psel && penable && pready && {paddr[11:2], 2'b00} == a;
endsequence
sequence s_wr(logic [11:0] a);
    s_acc(a) ##0 pwrite;
endsequence
sequence s_rd(logic [11:0] a);
    s_acc(a) ##0 !pwrite;
endsequence
AST_RST_CLEAN: assert property ($rose(presetn) |-> analog_out == '0 && !convert_done)
    else $error("outputs not clear after reset");
AST_REF_NOW: assert property (s_wr(`SARRC_OFF_SETUP) |=>
    analog_out.ref_select == $past(pwdata[7:6])) else $error("reference not applied");
AST_GAIN: assert property (s_wr(`SARRC_OFF_GAIN) |=>
    analog_out.gain_select == $past(pwdata[1:0])) else $error("gain not applied");
AST_POWER: assert property (s_wr(`SARRC_OFF_CTRL) |=>
    analog_out.converter_on == $past(pwdata[7])) else $error("power not following enable");
AST_TRIAL_MSB: assert property ($fell(analog_out.sample_hold) |->
    analog_out.trial_code == `SARRC_RES_MSB_MASK) else $error("first trial not msb");
AST_SAMPLE_LEN: assert property ($fell(analog_out.sample_hold) |->
    sh_cnt_r == (13'd4 << ps_r) || sh_cnt_r == (13'd52 << ps_r)) else $error("bad sample time");
AST_DONE_HOLD: assert property (convert_done && !clr_w |=> convert_done)
    else $error("done flag dropped");
AST_RIGHT: assert property (s_rd(`SARRC_OFF_RES_HIGH) ##0 !lj_r |-> prdata[31:2] == 30'h0)
    else $error("high bits not zero");
AST_LEFT: assert property (s_rd(`SARRC_OFF_RES_LOW) ##0 lj_r |->
    prdata[5:0] == 6'h00 && prdata[31:8] == 24'h0) else $error("left layout wrong");
AST_READY: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("ready not one cycle");
AST_SLVERR: assert property (psel && penable && pready && paddr[11:2] > 10'h004 |-> pslverr)
    else $error("unmapped not refused");
endmodule

bind sarrc_top sarrc_top_chk u_chk
(
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .comp_in(comp_in), .analog_out(analog_out), .convert_done(convert_done)
);

// ### sarrc_core_model.sv
`timescale 1ns/1ps

module sarrc_core_model
(
    // Clock
    input  wire logic                     pclk,
    // Controls from the block
    input  wire sarrc_pkg::sarrc_analog_t analog_in,
    // Test level before routing offsets
    input  wire logic [9:0]               level,
    // Comparator
    output logic                          comp_in
);
logic       tog_r = 1'b0;
logic [9:0] eff;
// Route and gain shift the level so a wrong code shows in the result
assign eff = level ^ {4'h0, analog_in.channel_select, analog_in.gain_select};
// Unpowered comparator wanders rather than holding a clean level
always_ff @(posedge pclk)
begin
    tog_r <= !tog_r;
end
assign comp_in = analog_in.converter_on ? (eff >= analog_in.trial_code) : tog_r;
endmodule

// ### sarrc_top_bench.sv
`timescale 1ns/1ps
`include "sarrc_regs.svh"

module sarrc_top_bench;
localparam logic [11:0] A_SET = `SARRC_OFF_SETUP;
localparam logic [11:0] A_CTL = `SARRC_OFF_CTRL;
localparam logic [11:0] A_LO  = `SARRC_OFF_RES_LOW;
localparam logic [11:0] A_HI  = `SARRC_OFF_RES_HIGH;
localparam logic [11:0] A_GN  = `SARRC_OFF_GAIN;
logic                     pclk, presetn, psel, penable, pwrite, comp_in;
logic                     pready, pslverr, convert_done, serr;
logic [11:0]              paddr;
logic [31:0]              pwdata, prdata, rd;
logic [9:0]               level, code;
sarrc_pkg::sarrc_analog_t analog_out;
int                       err_count = 0, checked = 0, cyc = 0;

sarrc_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .comp_in(comp_in), .analog_out(analog_out), .convert_done(convert_done));
sarrc_core_model u_core (.pclk(pclk), .analog_in(analog_out), .level(level), .comp_in(comp_in));

initial
begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
end
always @(posedge pclk) cyc <= cyc + 1;
////////////////////////////////////////////////////////////////////////////////
task automatic close_out();
    $display("Checks %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
        $display("ALL TESTS PASSED");
    else
        $display("TESTS FAILED");
    $finish;
endtask
task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
        err_count++;
        $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
endtask
// Idle cycle first, so back-to-back calls never drive twice in one step
task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
        @(posedge pclk);
        n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
    begin
        err_count++;
        close_out();
    end
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
endtask
task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
endtask
task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
endtask
// Clears the flag and starts in one write, then times the completion
task automatic run_conv(input int lo, input int hi);
    int c0;
    int n;
    wr(A_CTL, 8'hD0);
    c0 = cyc;
    rdc(A_CTL, 32'hC0);
    n = 0;
    while (convert_done !== 1'b1 && n < 2000)
    begin
        @(posedge pclk);
        n++;
    end
    if (convert_done !== 1'b1)
    begin
        err_count++;
        close_out();
    end
    chk({31'h0, (cyc - c0 >= lo && cyc - c0 <= hi)}, 32'h1);
    rdc(A_CTL, 32'h90);
endtask
////////////////////////////////////////////////////////////////////////////////
task automatic t_reset();
    chk({12'h0, analog_out}, 32'h0);
    for (int i = 0; i < 5; i++) rdc(12'(i * 4), 32'h0);
    $display("Test reset done");
endtask
task automatic t_setup();
    for (int g = 0; g < 4; g++)
    begin
        wr(A_GN, 8'(g));
        @(negedge pclk);
        chk({30'h0, analog_out.gain_select}, 32'(g));
    end
    for (int r = 0; r < 4; r++)
    begin
        wr(A_SET, {2'(r), 2'b00, 4'(r * 5)});
        @(negedge pclk);
        chk({30'h0, analog_out.ref_select}, 32'(r));
        // Channel reaches the pins one cycle after the register
        @(negedge pclk);
        chk({28'h0, analog_out.channel_select}, 32'(r * 5));
    end
    $display("Test setup done");
endtask
task automatic t_refused();
    wr(A_CTL, 8'h40);
    rdc(A_CTL, 32'h0);
    wr(A_LO, 8'hFF);
    rdc(A_LO, 32'h0);
    rdc(A_HI, 32'h0);
    rdc(12'h020, 32'h0);
    chk({31'h0, serr}, 32'h1);
    $display("Test refused done");
endtask
task automatic t_conv();
    wr(A_SET, 8'h05);
    code = level ^ 10'h017;
    run_conv(100, 108);
    chk({31'h0, convert_done}, 32'h1);
    rdc(A_LO, {24'h0, code[7:0]});
    rdc(A_HI, {30'h0, code[9:8]});
    run_conv(51, 54);
    wr(A_SET, 8'h25);
    rdc(A_HI, {24'h0, code[9:2]});
    rdc(A_LO, {24'h0, code[1:0], 6'h00});
    wr(A_SET, 8'h05);
    $display("Test convert done");
endtask
task automatic t_lock();
    rdc(A_LO, {24'h0, code[7:0]});
    level <= 10'h3E8;
    run_conv(51, 54);
    rdc(A_HI, {30'h0, code[9:8]});
    run_conv(51, 54);
    rdc(A_LO, 32'hFF);
    rdc(A_HI, 32'h3);
    $display("Test lock done");
endtask
task automatic t_off();
    wr(A_CTL, 8'h10);
    @(negedge pclk);
    chk({31'h0, analog_out.converter_on}, 32'h0);
    chk({31'h0, convert_done}, 32'h0);
    run_conv(100, 108);
    $display("Test power done");
endtask
////////////////////////////////////////////////////////////////////////////////
initial
begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    level = 10'h2B5;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_setup();
    t_refused();
    t_conv();
    t_lock();
    t_off();
    close_out();
end
endmodule
